/* File: shared/wake_pkg.sv */
// Constants shared by the wake and power-management logic.
package wake_pkg;
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CLEAR = 8'h04;
    localparam logic [7:0] OFF_IRQ_EN = 8'h08;
    localparam logic [7:0] OFF_WAKE_CTRL = 8'h0c;
    localparam logic [7:0] OFF_PM_CSR = 8'h10;
    localparam logic [7:0] OFF_DRV_AREA = 8'h14;
    localparam logic [7:0] OFF_STA_LO = 8'h18;
    localparam logic [7:0] OFF_STA_HI = 8'h1c;
    localparam logic [7:0] OFF_ROM = 8'h20;
    localparam int BIT_WAKE_EN = 22;
    localparam int BIT_SIG_EN = 8;
    localparam int BIT_SIG_STS = 15;
    localparam int BIT_WAKE_IRQ = 28;
    localparam int BIT_SLEEP = 31;
    localparam int BIT_ROM_DONE = 0;
    localparam int BIT_ROM_BUSY = 31;
    localparam int ROM_ACCESS_CYC = 7;
    localparam int ROM_READ_CYC = 8;
    localparam int SYNC_STAGES = 2;
    localparam int ROM_SAMPLE_CYC = ROM_ACCESS_CYC + SYNC_STAGES;
    localparam int ROM_CYC = (ROM_SAMPLE_CYC > ROM_READ_CYC) ? ROM_SAMPLE_CYC : ROM_READ_CYC;
    localparam logic [3:0] ROM_LAST = 4'(ROM_CYC - 1);
    localparam logic [2:0] EE_HALF_LAST = 3'h3;
    localparam logic [8:0] EE_CMD = 9'h180;
    localparam logic [5:0] EE_CMD_LAST = 6'h08;
    localparam logic [5:0] EE_DATA_LAST = 6'h2f;
    localparam logic [7:0] SYNC_BYTE = 8'hff;
    localparam logic [2:0] SYNC_LAST = 3'h5;
    localparam logic [2:0] ADDR_LAST = 3'h5;
    localparam logic [3:0] COPY_LAST = 4'hf;
endpackage

/* File: shared/wake_if.sv */
// Carrier between the power-management core and the wake pattern detector.
`timescale 1ns/10ps
interface wake_if;
    logic [47:0] station;
    logic enable;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_sof;
    logic hit;
    modport core (output station, output enable, output rx_valid, output rx_data, output rx_sof, input hit);
    modport det (input station, input enable, input rx_valid, input rx_data, input rx_sof, output hit);
endinterface

/* File: verilog/wake_pattern_detect.sv */
// Wake pattern frame detector on the receive byte stream.
`timescale 1ns/10ps
module wake_pattern_detect (
    input wire logic pclk,
    input wire logic presetn,
    wake_if.det w
);
    typedef struct packed {
        logic [2:0] sync_cnt;
        logic [2:0] byte_idx;
        logic [3:0] copy_cnt;
        logic matching;
        logic hit;
    } det_s;

    det_s q;
    det_s d;

    function automatic logic [7:0] addr_byte(input logic [47:0] sta, input logic [2:0] idx);
        return sta[8 * (5 - int'(idx)) +: 8];
    endfunction

    always_comb begin
        det_s n;
        n = q;
        n.hit = 1'b0;
        if (w.rx_sof) begin
            n.sync_cnt = '0;
            n.byte_idx = '0;
            n.copy_cnt = '0;
            n.matching = 1'b0;
        end
        if (!w.enable) begin
            n.sync_cnt = '0;
            n.matching = 1'b0;
        end else if (w.rx_valid) begin
            if (n.matching) begin
                if (w.rx_data == addr_byte(w.station, n.byte_idx)) begin
                    if (n.byte_idx == wake_pkg::ADDR_LAST) begin
                        n.byte_idx = '0;
                        if (n.copy_cnt == wake_pkg::COPY_LAST) begin
                            n.hit = 1'b1;
                            n.matching = 1'b0;
                            n.sync_cnt = '0;
                        end else begin
                            n.copy_cnt = n.copy_cnt + 4'h1;
                        end
                    end else begin
                        n.byte_idx = n.byte_idx + 3'h1;
                    end
                end else if (w.rx_data == wake_pkg::SYNC_BYTE && n.byte_idx == '0 && n.copy_cnt == '0) begin
                    n.matching = 1'b1;
                end else begin
                    n.matching = 1'b0;
                    n.byte_idx = '0;
                    n.copy_cnt = '0;
                    n.sync_cnt = (w.rx_data == wake_pkg::SYNC_BYTE) ? 3'h1 : 3'h0;
                end
            end else if (w.rx_data == wake_pkg::SYNC_BYTE) begin
                if (n.sync_cnt == wake_pkg::SYNC_LAST) begin
                    n.matching = 1'b1;
                    n.byte_idx = '0;
                    n.copy_cnt = '0;
                end else begin
                    n.sync_cnt = n.sync_cnt + 3'h1;
                end
            end else begin
                n.sync_cnt = '0;
            end
        end
        d = n;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign w.hit = q.hit;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_hit_needs_enable: assert property (w.hit |-> $past(w.enable)) else $error("Hit without detection enabled.");
    a_hit_single_pulse: assert property (w.hit |=> !w.hit) else $error("Hit lasted more than one cycle.");
endmodule

/* File: verilog/network_wake_power_mgmt.sv */
// Wake, sleep and boot ROM control of the network controller, with an APB register slave.
//
// Function
// - Load station address at power-up, then arm.
// - Remote power-on hit drives power event low.
// - Remote power-on arms itself without programming.
// - Host powered: detect when software enabled.
// - Host powered: power event needs the event enable; wake enable gates it only through detection.
// - Wake interrupt needs wake and interrupt enables.
// - Sleep bit halts transmit and receive.
// - In sleep only configuration registers answer.
// - ROM read lasts eight cycles, seven access; the strobes here stay low for nine cycles.
// - Sleep overrides wake pattern detection.
// - Host-powered wake hit sets interrupt status flag.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/10ps
module network_wake_power_mgmt (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic host_powered,
    input wire logic ee_do,
    output logic ee_cs,
    output logic ee_sk,
    output logic ee_di,
    output logic [15:0] rom_addr,
    output logic rom_ce_n,
    output logic rom_oe_n,
    input wire logic [7:0] rom_data,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_sof,
    output logic power_mgmt_event_n,
    output logic inta_n,
    output logic irq,
    output logic net_halt
);
    typedef enum logic [1:0] {LD_CMD, LD_DATA, LD_DONE} load_e;

    typedef struct packed {
        load_e ld_state;
        logic [2:0] ee_div;
        logic [5:0] ee_bit;
        logic [8:0] ee_cmd;
        logic ee_cs;
        logic ee_sk;
        logic [47:0] station;
        logic loaded;
        logic ee_do_s1;
        logic ee_do_s2;
        logic hp_s1;
        logic hp_s2;
        logic [7:0] rom_s1;
        logic [7:0] rom_s2;
        logic wake_en;
        logic sig_en;
        logic sig_sts;
        logic sleep;
        logic wake_flag;
        logic rom_flag;
        logic irq_en_wake;
        logic irq_en_rom;
        logic rom_busy;
        logic [3:0] rom_cnt;
        logic [15:0] rom_addr;
        logic [7:0] rom_rd;
        logic rom_ce_n;
        logic rom_oe_n;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic event_n;
        logic inta_n;
        logic irq;
    } state_s;

    localparam state_s RST_STATE = '{ld_state: LD_CMD, ee_cmd: wake_pkg::EE_CMD, ee_cs: 1'b1, rom_ce_n: 1'b1,
                                     rom_oe_n: 1'b1, event_n: 1'b1, inta_n: 1'b1, default: '0};

    state_s q;
    state_s d;
    wake_if w ();

    function automatic logic refused(input logic [7:0] a, input logic slp);
        logic known;
        logic cfg;
        known = 1'b0;
        cfg = 1'b0;
        if (a == wake_pkg::OFF_PM_CSR || a == wake_pkg::OFF_DRV_AREA) begin
            known = 1'b1;
            cfg = 1'b1;
        end else if (a == wake_pkg::OFF_STATUS || a == wake_pkg::OFF_CLEAR || a == wake_pkg::OFF_IRQ_EN) begin
            known = 1'b1;
        end else if (a == wake_pkg::OFF_WAKE_CTRL || a == wake_pkg::OFF_ROM) begin
            known = 1'b1;
        end else if (a == wake_pkg::OFF_STA_LO || a == wake_pkg::OFF_STA_HI) begin
            known = 1'b1;
        end
        return !known || (slp && !cfg);
    endfunction

    wake_pattern_detect u_detect (
        .pclk(pclk),
        .presetn(presetn),
        .w(w.det)
    );

    assign w.station = q.station;
    assign w.enable = q.loaded && !q.sleep && (!q.hp_s2 || q.wake_en);
    assign w.rx_valid = rx_valid;
    assign w.rx_data = rx_data;
    assign w.rx_sof = rx_sof;

    always_comb begin
        logic acc;
        logic wr_go;
        logic [31:0] rd;
        d = q;
        acc = psel && penable && !q.pready;
        wr_go = psel && penable && q.pready && pwrite && !q.pslverr;
        rd = '0;
        d.ee_do_s1 = ee_do;
        d.ee_do_s2 = q.ee_do_s1;
        d.hp_s1 = host_powered;
        d.hp_s2 = q.hp_s1;
        d.rom_s1 = rom_data;
        d.rom_s2 = q.rom_s1;

        // Serial memory read of the station address, sampled on the falling clock half.
        if (q.ld_state != LD_DONE) begin
            if (q.ee_div == wake_pkg::EE_HALF_LAST) begin
                d.ee_div = '0;
                d.ee_sk = !q.ee_sk;
                if (q.ee_sk) begin
                    d.ee_bit = q.ee_bit + 6'h01;
                    if (q.ld_state == LD_CMD) begin
                        d.ee_cmd = {q.ee_cmd[7:0], 1'b0};
                        if (q.ee_bit == wake_pkg::EE_CMD_LAST) begin
                            d.ld_state = LD_DATA;
                            d.ee_bit = '0;
                        end
                    end else begin
                        d.station = {q.station[46:0], q.ee_do_s2};
                        if (q.ee_bit == wake_pkg::EE_DATA_LAST) begin
                            d.ld_state = LD_DONE;
                            d.ee_cs = 1'b0;
                            d.loaded = 1'b1;
                        end
                    end
                end
            end else begin
                d.ee_div = q.ee_div + 3'h1;
            end
        end

        // ROM read cycle: strobes held for the whole cycle, data taken at its last clock.
        if (q.rom_busy) begin
            d.rom_cnt = q.rom_cnt + 4'h1;
            if (q.rom_cnt == wake_pkg::ROM_LAST) begin
                d.rom_busy = 1'b0;
                d.rom_ce_n = 1'b1;
                d.rom_oe_n = 1'b1;
                d.rom_rd = q.rom_s2;
            end
        end

        d.pready = acc;
        d.pslverr = acc && refused(paddr, q.sleep);
        if (acc && !refused(paddr, q.sleep) && !pwrite) begin
            if (paddr == wake_pkg::OFF_STATUS) begin
                rd[wake_pkg::BIT_WAKE_IRQ] = q.wake_flag;
                rd[wake_pkg::BIT_ROM_DONE] = q.rom_flag;
            end else if (paddr == wake_pkg::OFF_IRQ_EN) begin
                rd[wake_pkg::BIT_WAKE_IRQ] = q.irq_en_wake;
                rd[wake_pkg::BIT_ROM_DONE] = q.irq_en_rom;
            end else if (paddr == wake_pkg::OFF_WAKE_CTRL) begin
                rd[wake_pkg::BIT_WAKE_EN] = q.wake_en;
            end else if (paddr == wake_pkg::OFF_PM_CSR) begin
                rd[wake_pkg::BIT_SIG_EN] = q.sig_en;
                rd[wake_pkg::BIT_SIG_STS] = q.sig_sts;
            end else if (paddr == wake_pkg::OFF_DRV_AREA) begin
                rd[wake_pkg::BIT_SLEEP] = q.sleep;
            end else if (paddr == wake_pkg::OFF_STA_LO) begin
                rd = q.station[31:0];
            end else if (paddr == wake_pkg::OFF_STA_HI) begin
                rd[15:0] = q.station[47:32];
            end else if (paddr == wake_pkg::OFF_ROM) begin
                rd[wake_pkg::BIT_ROM_BUSY] = q.rom_busy;
                rd[7:0] = q.rom_rd;
            end
        end
        d.prdata = acc ? rd : '0;

        if (wr_go) begin
            if (paddr == wake_pkg::OFF_CLEAR) begin
                if (pwdata[wake_pkg::BIT_WAKE_IRQ]) begin
                    d.wake_flag = 1'b0;
                end
                if (pwdata[wake_pkg::BIT_ROM_DONE]) begin
                    d.rom_flag = 1'b0;
                end
            end else if (paddr == wake_pkg::OFF_IRQ_EN) begin
                d.irq_en_wake = pwdata[wake_pkg::BIT_WAKE_IRQ];
                d.irq_en_rom = pwdata[wake_pkg::BIT_ROM_DONE];
            end else if (paddr == wake_pkg::OFF_WAKE_CTRL) begin
                d.wake_en = pwdata[wake_pkg::BIT_WAKE_EN];
            end else if (paddr == wake_pkg::OFF_PM_CSR) begin
                d.sig_en = pwdata[wake_pkg::BIT_SIG_EN];
                if (pwdata[wake_pkg::BIT_SIG_STS]) begin
                    d.sig_sts = 1'b0;
                end
            end else if (paddr == wake_pkg::OFF_DRV_AREA) begin
                d.sleep = pwdata[wake_pkg::BIT_SLEEP];
            end else if (paddr == wake_pkg::OFF_ROM && !q.rom_busy) begin
                d.rom_busy = 1'b1;
                d.rom_cnt = '0;
                d.rom_addr = pwdata[15:0];
                d.rom_ce_n = 1'b0;
                d.rom_oe_n = 1'b0;
            end
        end

        // Events come last so that a set in the same cycle as a clear wins.
        if (q.rom_busy && q.rom_cnt == wake_pkg::ROM_LAST) begin
            d.rom_flag = 1'b1;
        end
        if (w.hit) begin
            d.sig_sts = 1'b1;
            if (q.hp_s2 && q.wake_en) begin
                d.wake_flag = 1'b1;
            end
        end

        // The mode is taken from the new synchronised level so the output never lags the synchronised host power level.
        d.event_n = !(d.sig_sts && (d.sig_en || !d.hp_s2));
        d.irq = (d.wake_flag && d.irq_en_wake && d.wake_en) || (d.rom_flag && d.irq_en_rom);
        d.inta_n = !d.irq;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= RST_STATE;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign ee_cs = q.ee_cs;
    assign ee_sk = q.ee_sk;
    assign ee_di = q.ee_cmd[8];
    assign rom_addr = q.rom_addr;
    assign rom_ce_n = q.rom_ce_n;
    assign rom_oe_n = q.rom_oe_n;
    assign power_mgmt_event_n = q.event_n;
    assign inta_n = q.inta_n;
    assign irq = q.irq;
    // Halting the datapath is a level so it also stops frames already in progress.
    assign net_halt = q.sleep;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence rom_hold;
        (!rom_ce_n && !rom_oe_n) [*8];
    endsequence

    a_load_then_arm: assert property ($rose(q.loaded) |-> !ee_cs && q.ld_state == LD_DONE) else $error("Load end wrong.");
    a_rpo_event_low: assert property (w.hit && !q.hp_s2 && !q.hp_s1 |-> ##1 !power_mgmt_event_n) else $error("No event.");
    a_rpo_self_arm: assert property (q.loaded && !q.hp_s2 && !q.sleep |-> w.enable) else $error("Not armed.");
    a_detect_enabled: assert property (q.loaded && q.hp_s2 && q.wake_en && !q.sleep |-> w.enable) else $error("Off.");
    a_event_gating: assert property (!power_mgmt_event_n && q.hp_s2 |-> q.sig_en) else $error("Event without enable.");
    a_inta_gating: assert property (!inta_n && !(q.rom_flag && q.irq_en_rom) |-> q.wake_en && q.irq_en_wake)
        else $error("INTA without enables.");
    a_sleep_refuse: assert property (psel && penable && pready && q.sleep && paddr == wake_pkg::OFF_WAKE_CTRL
        |-> pslverr) else $error("Access taken in sleep.");
    a_rom_cycle: assert property ($fell(rom_ce_n) |-> rom_hold) else $error("ROM cycle too short.");
    a_sleep_no_detect: assert property (q.sleep |-> !w.enable ##1 !w.hit) else $error("Detect in sleep.");
    a_wake_flag_set: assert property (w.hit && q.hp_s2 && q.wake_en |=> q.wake_flag) else $error("Flag not set.");
endmodule

/* File: tb/board_model.sv */
// Serial configuration memory and boot ROM models beside the device.
`timescale 1ns/10ps
module board_model #(
    parameter logic [47:0] STATION = 48'h0
) (
    input wire logic pclk,
    input wire logic ee_cs,
    input wire logic ee_sk,
    input wire logic ee_di,
    output logic ee_do,
    input wire logic [15:0] rom_addr,
    input wire logic rom_ce_n,
    input wire logic rom_oe_n,
    output logic [7:0] rom_data
);
    int bit_cnt;
    int acc_cnt;
    logic sk_q;
    initial begin
        bit_cnt = 0;
        acc_cnt = 0;
        sk_q = 1'b0;
        ee_do = 1'b0;
        rom_data = 8'h00;
    end
    // The memory shifts out the station identity MSB first after the nine command bits.
    always @(posedge pclk) begin
        sk_q <= ee_sk;
        if (!ee_cs) begin
            bit_cnt <= 0;
            ee_do <= ~ee_do;
        end else if (ee_sk && !sk_q) begin
            bit_cnt <= bit_cnt + 1;
        end else if (!ee_sk && sk_q && bit_cnt >= 9 && bit_cnt < 57) begin
            ee_do <= STATION[56-bit_cnt];
        end
    end
    // The ROM is slow on purpose: data is only good after six strobe cycles, so early sampling shows.
    always @(posedge pclk) begin
        if (rom_ce_n || rom_oe_n) begin
            acc_cnt <= 0;
            rom_data <= ~rom_data;
        end else begin
            acc_cnt <= acc_cnt + 1;
            rom_data <= (acc_cnt >= 5) ? (rom_addr[7:0] ^ rom_addr[15:8] ^ 8'h5a) : ~rom_data;
        end
    end
endmodule

/* File: tb/network_wake_power_mgmt_test.sv */
// Self-checking testbench of the wake, sleep and boot ROM control block.
`timescale 1ns/10ps
module network_wake_power_mgmt_test;
    localparam logic [47:0] STATION = 48'h02a4_3c5e_9170;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, ee_do, ee_cs, ee_sk, ee_di, rom_ce_n, rom_oe_n;
    logic host_powered = 1'b0;
    logic [15:0] rom_addr;
    logic [7:0] rom_data;
    logic rx_valid = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic rx_sof = 1'b0;
    logic power_mgmt_event_n, inta_n, irq, net_halt;
    logic [33:0] notes[$];
    logic [33:0] n;
    int fail_count = 0;
    int total_checks = 0;
    int seed = 70632;
    int cycles = 0;
    int cnt;
    always #50 pclk = ~pclk;
    network_wake_power_mgmt u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .host_powered(host_powered), .ee_do(ee_do), .ee_cs(ee_cs), .ee_sk(ee_sk),
        .ee_di(ee_di), .rom_addr(rom_addr), .rom_ce_n(rom_ce_n), .rom_oe_n(rom_oe_n), .rom_data(rom_data),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_sof(rx_sof), .power_mgmt_event_n(power_mgmt_event_n),
        .inta_n(inta_n), .irq(irq), .net_halt(net_halt));
    board_model #(.STATION(STATION)) u_board (.pclk(pclk), .ee_cs(ee_cs), .ee_sk(ee_sk), .ee_di(ee_di),
        .ee_do(ee_do), .rom_addr(rom_addr), .rom_ce_n(rom_ce_n), .rom_oe_n(rom_oe_n), .rom_data(rom_data));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bus(input logic [33:0] nt);
        if (nt[33]) begin
            chk(prdata, nt[31:0]);
        end
        chk({31'h0, pslverr}, {31'h0, nt[32]});
    endtask
    // Reads carry an expected word; writes only an expected error flag.
    always @(posedge pclk) begin
        if (pready === 1'b1 && notes.size() > 0) begin
            n = notes.pop_front();
            chk_bus(n);
        end
    end
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic err);
        notes.push_back({!w, err, d});
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= w ? d : 32'h0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic send(input int copies);
        for (int i = 0; i < 4 + 6 + 6 * copies; i++) begin
            @(posedge pclk);
            rx_valid <= 1'b1;
            rx_sof <= (i == 0);
            if (i < 4) rx_data <= 8'($random(seed)) & 8'hfe;
            else if (i < 10) rx_data <= 8'hff;
            else rx_data <= STATION[47-8*((i-10)%6)-:8];
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles >= 20000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (600) @(posedge pclk);
        chk({ee_cs, ee_sk}, 2'h0);
        apb(wake_pkg::OFF_STA_LO, 1'b0, STATION[31:0], 1'b0);
        apb(wake_pkg::OFF_STA_HI, 1'b0, {16'h0, STATION[47:32]}, 1'b0);
        send(16);
        chk(power_mgmt_event_n, 1'b0);
        apb(wake_pkg::OFF_PM_CSR, 1'b1, 32'h0000_8000, 1'b0);
        apb(wake_pkg::OFF_CLEAR, 1'b1, 32'h1000_0000, 1'b0);
        repeat (4) @(posedge pclk);
        chk(power_mgmt_event_n, 1'b1);
        $display("test remote power-on done");
        host_powered <= 1'b1;
        repeat (4) @(posedge pclk);
        send(16);
        chk(power_mgmt_event_n, 1'b1);
        apb(wake_pkg::OFF_STATUS, 1'b0, 32'h0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            apb(wake_pkg::OFF_WAKE_CTRL, 1'b1, 32'h0040_0000, 1'b0);
            apb(wake_pkg::OFF_PM_CSR, 1'b1, {23'h0, i[0], 8'h0}, 1'b0);
            apb(wake_pkg::OFF_IRQ_EN, 1'b1, {3'h0, i[1], 28'h0}, 1'b0);
            send(16);
            chk(power_mgmt_event_n, !i[0]);
            chk(inta_n, !i[1]);
            chk(irq, i[1]);
            apb(wake_pkg::OFF_STATUS, 1'b0, 32'h1000_0000, 1'b0);
            apb(wake_pkg::OFF_CLEAR, 1'b1, 32'h1000_0000, 1'b0);
            apb(wake_pkg::OFF_PM_CSR, 1'b1, {16'h0, 1'b1, 6'h0, i[0], 8'h0}, 1'b0);
            repeat (4) @(posedge pclk);
            chk({inta_n, power_mgmt_event_n}, 2'h3);
        end
        send(15);
        chk({inta_n, power_mgmt_event_n}, 2'h3);
        $display("test remote wake-up done");
        apb(wake_pkg::OFF_DRV_AREA, 1'b1, 32'h8000_0000, 1'b0);
        repeat (2) @(posedge pclk);
        chk(net_halt, 1'b1);
        apb(wake_pkg::OFF_STATUS, 1'b0, 32'h0, 1'b1);
        apb(wake_pkg::OFF_DRV_AREA, 1'b0, 32'h8000_0000, 1'b0);
        send(16);
        chk({inta_n, power_mgmt_event_n}, 2'h3);
        apb(wake_pkg::OFF_DRV_AREA, 1'b1, 32'h0, 1'b0);
        repeat (2) @(posedge pclk);
        chk(net_halt, 1'b0);
        apb(8'h40, 1'b0, 32'h0, 1'b1);
        $display("test sleep done");
        apb(wake_pkg::OFF_ROM, 1'b1, 32'h0000_12c4, 1'b0);
        cnt = 0;
        while (rom_ce_n !== 1'b0 && cnt < 20) begin
            @(posedge pclk);
            cnt++;
        end
        chk({rom_ce_n, rom_oe_n}, 2'h0);
        cnt = 0;
        while (rom_ce_n === 1'b0 && cnt < 40) begin
            @(posedge pclk);
            cnt++;
        end
        chk(cnt >= 8, 1'b1);
        chk(rom_addr, 16'h12c4);
        repeat (2) @(posedge pclk);
        apb(wake_pkg::OFF_ROM, 1'b0, {24'h0, 8'h12 ^ 8'hc4 ^ 8'h5a}, 1'b0);
        apb(wake_pkg::OFF_STATUS, 1'b0, 32'h1, 1'b0);
        apb(wake_pkg::OFF_IRQ_EN, 1'b1, 32'h1, 1'b0);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b1);
        apb(wake_pkg::OFF_CLEAR, 1'b1, 32'h1, 1'b0);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b0);
        $display("test boot rom done");
        results();
    end
endmodule
